// ---- rtl/dspip_hyst.sv ----
`timescale 1ns/1ns
// level detector with separate on and off thresholds
module dspip_hyst #(
   parameter int unsigned W = 14
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // level and thresholds
   input wire logic [W-1:0] level,
   input wire logic [W-1:0] on_lvl,
   input wire logic [W-1:0] off_lvl,
   // detector state
   output logic valid_r
);

   logic valid_nxt;

   // set at on level, clear below off level
   assign valid_nxt = valid_r ? (level >= off_lvl) : (level >= on_lvl);

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         valid_r <= 1'b0;
      else
         valid_r <= valid_nxt;
   end

endmodule

// ---- rtl/dspip_pkg.sv ----
// How it works
// - function select decides meaning of both conduits, reads differ from writes
// - parameter address is 16 bits, parameter value is 14 bits
// - select 0: low conduit loads address 7:0, high loads 15:8
// - select 1: conduits carry value bytes for last loaded address
// - value high byte gives only the upper six bits of 14
// - select 2 read: bit7 data available, bit6 detected, 4:0 tone type
// - select 2 high write: squaring, cascade disable, five reporting enables
// - select 2 low write: DTMF digit in 6:3, tone type in 2:0
// - transmit full-scale level parameter, default 4096
// - DTMF high-tone level parameter, default 4868
// - DTMF twist ratio parameter, default 3277
// - user tone frequency equals value times 9600/512 Hz, default 91
// - progress energy compared against detect level, default 4096
// - four user detector centres, defaults 4987 and 536
// - tone generation level scales selected tones, default 2896
// - shared sensitivity for all four user detectors, default 4096
// - carrier valid at on level, invalid below off level
// - answer tone valid at on level, invalid below off level
// - only highest-priority enabled detected tone is reported
// - tone type 110 generates user tone at tone generation level
package dspip_pkg;

   // sample rate and tick divider
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned SAMPLE_HZ = 9600;
   localparam int unsigned SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
   localparam int unsigned PHASE_W = 9;

   // conduit widths
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned VAL_W = 14;
   localparam int unsigned VAL_HI_W = 6;

   // function select codes
   localparam logic [7:0] FSEL_ADDR = 8'h00;
   localparam logic [7:0] FSEL_VALUE = 8'h01;
   localparam logic [7:0] FSEL_TONE = 8'h02;
   localparam logic [7:0] FSEL_RESET = 8'h00;

   // host register select
   typedef enum logic [1:0] {
      DSPIP_SEL_FUNC = 2'b00,
      DSPIP_SEL_HIGH = 2'b01,
      DSPIP_SEL_LOW = 2'b10
   } dspip_sel_t;

   // tone status and control fields
   localparam int unsigned STAT_AVAIL_BIT = 7;
   localparam int unsigned STAT_DET_BIT = 6;
   localparam int unsigned CTL_SQUARE_BIT = 7;
   localparam int unsigned CTL_CASC_BIT = 6;
   localparam int unsigned REP_DTMF = 0;
   localparam int unsigned REP_ANS = 1;
   localparam int unsigned REP_V23 = 2;
   localparam int unsigned REP_U12 = 3;
   localparam int unsigned REP_U34 = 4;
   localparam int unsigned GEN_DIGIT_LSB = 3;
   localparam logic [2:0] GEN_TYPE_USER = 3'b110;

   // reported tone type codes
   localparam logic [4:0] TT_NONE = 5'h00;
   localparam logic [4:0] TT_ANSWER = 5'h01;
   localparam logic [4:0] TT_V23 = 5'h02;
   localparam logic [4:0] TT_USER1 = 5'h04;
   localparam logic [4:0] TT_DTMF = 5'h10;

   // parameter map
   localparam int unsigned NPARAM = 15;
   localparam logic [15:0] PADDR [NPARAM] = '{16'h0002, 16'h0003, 16'h0004,
      16'h0005, 16'h0006, 16'h0007, 16'h0008, 16'h0009, 16'h000a, 16'h000b,
      16'h000e, 16'h0024, 16'h0025, 16'h0026, 16'h0027};
   localparam logic [13:0] PRESET [NPARAM] = '{14'h1000, 14'h1304, 14'h0ccd,
      14'h005b, 14'h1000, 14'h137b, 14'h0218, 14'h137b, 14'h0218, 14'h0b50,
      14'h1000, 14'h0a3c, 14'h0ce4, 14'h0043, 14'h0025};
   localparam int unsigned IDX_TONE_FREQ = 3;
   localparam int unsigned IDX_PROG_LVL = 4;
   localparam int unsigned IDX_GEN_LVL = 9;
   localparam int unsigned IDX_SENS = 10;
   localparam int unsigned IDX_CAR_ON = 11;
   localparam int unsigned IDX_CAR_OFF = 12;
   localparam int unsigned IDX_ANS_ON = 13;
   localparam int unsigned IDX_ANS_OFF = 14;
   localparam logic [4:0] IDX_NONE = 5'h1f;

   // address to slot lookup
   function automatic logic [4:0] dspip_slot(input logic [15:0] a);
      logic [4:0] s;
      s = IDX_NONE;
      for (int i = 0; i < NPARAM; i++)
         if (PADDR[i] == a)
            s = 5'(i);
      return s;
   endfunction

endpackage

// ---- rtl/dspip_pw_if.sv ----
`timescale 1ns/1ns
// parameter write path between conduit logic and the store
interface dspip_pw_if;
   logic wr;
   logic [15:0] addr;
   logic [13:0] data;
   modport src (output wr, output addr, output data);
   modport dst (input wr, input addr, input data);
endinterface

// ---- rtl/dspip_store.sv ----
`timescale 1ns/1ns
// parameter map storage, one slot per mapped address
module dspip_store
   import dspip_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // write path
   dspip_pw_if.dst pw,
   // stored values and unmapped flag
   output logic [NPARAM-1:0][13:0] params_r,
   output logic bad_addr_r
);

   logic [4:0] slot_w;

   // address decode
   assign slot_w = dspip_slot(pw.addr);

   // slot write, defaults after reset
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < NPARAM; i++)
            params_r[i] <= PRESET[i];
         bad_addr_r <= 1'b0;
      end
      else
      begin
         if (pw.wr && slot_w != IDX_NONE)
            params_r[slot_w] <= pw.data;
         bad_addr_r <= pw.wr && slot_w == IDX_NONE;
      end
   end

endmodule

// ---- rtl/dspip_top.sv ----
`timescale 1ns/1ns
// conduit register bank for the signal-processor parameters
module dspip_top
   import dspip_pkg::*;
#(
   parameter int unsigned SAMPLE_DIV = SAMPLE_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,

   // host conduit access
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [1:0] host_sel,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata_r,
   output logic host_rvalid_r,

   // line state
   input wire logic on_hook,
   input wire logic command_mode,

   // detector inputs
   input wire logic dtmf_hit,
   input wire logic [3:0] dtmf_code,
   input wire logic v23_hit,
   input wire logic [13:0] carrier_energy,
   input wire logic [13:0] answer_energy,
   input wire logic [13:0] progress_energy,
   input wire logic [3:0][13:0] user_energy,

   // parameter map
   output logic [NPARAM-1:0][13:0] params_r,
   output logic param_bad_addr_r,
   output logic param_refused_r,

   // tone control
   output logic square_en_r,
   output logic cascade_dis_r,
   output logic [4:0] report_en_r,
   output logic [3:0] dtmf_tx_digit_r,
   output logic [2:0] tone_type_r,

   // detection results
   output logic carrier_valid_r,
   output logic answer_valid_r,
   output logic progress_hit_r,
   output logic [3:0] user_hit_r,

   // user tone generator
   output logic user_tone_on_r,
   output logic [PHASE_W-1:0] user_tone_phase_r,
   output logic [13:0] user_tone_amp_r
);

   dspip_pw_if pw ();

   // conduit state
   logic [7:0] fsel_r;
   logic [15:0] addr_r;
   logic [VAL_HI_W-1:0] val_hi_r;
   logic [4:0] stat_type_r;
   logic stat_det_r;
   logic avail_r;
   logic pw_wr_r;
   logic [13:0] pw_data_r;

   // decoded accesses
   logic wr_func_w;
   logic wr_high_w;
   logic wr_low_w;
   logic rd_func_w;
   logic rd_low_w;
   logic mode_addr_w;
   logic mode_val_w;
   logic mode_tone_w;
   logic may_write_w;
   logic commit_w;
   logic status_read_w;

   // access decode steered by the function select
   assign wr_func_w = host_wr && host_sel == DSPIP_SEL_FUNC;
   assign wr_high_w = host_wr && host_sel == DSPIP_SEL_HIGH;
   assign wr_low_w = host_wr && host_sel == DSPIP_SEL_LOW;
   assign rd_func_w = host_rd && host_sel == DSPIP_SEL_FUNC;
   assign rd_low_w = host_rd && host_sel == DSPIP_SEL_LOW;
   assign mode_addr_w = fsel_r == FSEL_ADDR;
   assign mode_val_w = fsel_r == FSEL_VALUE;
   assign mode_tone_w = fsel_r == FSEL_TONE;

   // value commit only while idle on-hook
   assign may_write_w = on_hook && command_mode;
   assign commit_w = wr_low_w && mode_val_w && may_write_w;
   assign status_read_w = rd_low_w && mode_tone_w;

   // function select register
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         fsel_r <= FSEL_RESET;
      else if (wr_func_w)
         fsel_r <= host_wdata;
   end

   // parameter address bytes
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         addr_r <= '0;
      else if (wr_low_w && mode_addr_w)
         addr_r[7:0] <= host_wdata;
      else if (wr_high_w && mode_addr_w)
         addr_r[15:8] <= host_wdata;
   end

   // value high byte, top two bits dropped
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         val_hi_r <= '0;
      else if (wr_high_w && mode_val_w)
         val_hi_r <= host_wdata[VAL_HI_W-1:0];
   end

   // commit assembled value to the last loaded address
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pw_wr_r <= 1'b0;
         pw_data_r <= '0;
         param_refused_r <= 1'b0;
      end
      else
      begin
         pw_wr_r <= commit_w;
         if (commit_w)
            pw_data_r <= {val_hi_r, host_wdata};
         param_refused_r <= wr_low_w && mode_val_w && !may_write_w;
      end
   end

   assign pw.wr = pw_wr_r;
   assign pw.addr = addr_r;
   assign pw.data = pw_data_r;

   // parameter storage
   dspip_store u_store (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .pw(pw.dst),
      .params_r(params_r),
      .bad_addr_r(param_bad_addr_r)
   );

   // tone report and generation controls
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         square_en_r <= 1'b0;
         cascade_dis_r <= 1'b0;
         report_en_r <= '0;
         dtmf_tx_digit_r <= '0;
         tone_type_r <= '0;
      end
      else
      begin
         if (wr_high_w && mode_tone_w)
         begin
            square_en_r <= host_wdata[CTL_SQUARE_BIT];
            cascade_dis_r <= host_wdata[CTL_CASC_BIT];
            report_en_r <= host_wdata[4:0];
         end
         if (wr_low_w && mode_tone_w)
         begin
            dtmf_tx_digit_r <= host_wdata[GEN_DIGIT_LSB+:4];
            tone_type_r <= host_wdata[2:0];
         end
      end
   end

   // carrier and answer tone hysteresis
   dspip_hyst #(.W(VAL_W)) u_carrier (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .level(carrier_energy),
      .on_lvl(params_r[IDX_CAR_ON]),
      .off_lvl(params_r[IDX_CAR_OFF]),
      .valid_r(carrier_valid_r)
   );

   dspip_hyst #(.W(VAL_W)) u_answer (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .level(answer_energy),
      .on_lvl(params_r[IDX_ANS_ON]),
      .off_lvl(params_r[IDX_ANS_OFF]),
      .valid_r(answer_valid_r)
   );

   // threshold detectors
   logic [3:0] user_hit_nxt;
   logic progress_hit_nxt;

   assign progress_hit_nxt = progress_energy >= params_r[IDX_PROG_LVL];
   assign user_hit_nxt[0] = user_energy[0] >= params_r[IDX_SENS];
   assign user_hit_nxt[1] = user_energy[1] >= params_r[IDX_SENS];
   assign user_hit_nxt[2] = user_energy[2] >= params_r[IDX_SENS];
   assign user_hit_nxt[3] = user_energy[3] >= params_r[IDX_SENS];

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         progress_hit_r <= 1'b0;
         user_hit_r <= '0;
      end
      else
      begin
         progress_hit_r <= progress_hit_nxt;
         user_hit_r <= user_hit_nxt;
      end
   end

   // enabled hits in priority order
   logic en_dtmf_w;
   logic en_ans_w;
   logic en_v23_w;
   logic [3:0] en_user_w;
   logic [4:0] stat_type_nxt;
   logic stat_det_nxt;
   logic avail_set_w;

   assign en_dtmf_w = dtmf_hit && report_en_r[REP_DTMF];
   assign en_ans_w = answer_valid_r && report_en_r[REP_ANS];
   assign en_v23_w = v23_hit && report_en_r[REP_V23];
   assign en_user_w[1:0] = user_hit_r[1:0] & {2{report_en_r[REP_U12]}};
   assign en_user_w[3:2] = user_hit_r[3:2] & {2{report_en_r[REP_U34]}};

   // highest-priority enabled tone wins
   assign stat_type_nxt = en_dtmf_w ? (TT_DTMF | {1'b0, dtmf_code}) :
      en_ans_w ? TT_ANSWER :
      en_v23_w ? TT_V23 :
      en_user_w[0] ? TT_USER1 :
      en_user_w[1] ? 5'(TT_USER1 + 5'h01) :
      en_user_w[2] ? 5'(TT_USER1 + 5'h02) :
      en_user_w[3] ? 5'(TT_USER1 + 5'h03) : TT_NONE;
   assign stat_det_nxt = en_dtmf_w || en_ans_w || en_v23_w || |en_user_w;
   assign avail_set_w = stat_det_nxt && stat_type_nxt != stat_type_r;

   // status and data-available flag, set beats read clear
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stat_type_r <= TT_NONE;
         stat_det_r <= 1'b0;
         avail_r <= 1'b0;
      end
      else
      begin
         stat_type_r <= stat_type_nxt;
         stat_det_r <= stat_det_nxt;
         if (avail_set_w)
            avail_r <= 1'b1;
         else if (status_read_w)
            avail_r <= 1'b0;
      end
   end

   // read data selection
   logic [7:0] status_w;
   logic [7:0] rdata_nxt;

   assign status_w = {avail_r, stat_det_r, 1'b0, stat_type_r};
   assign rdata_nxt = rd_func_w ? fsel_r :
      status_read_w ? status_w : 8'h00;

   // read answer one cycle after the strobe
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         host_rdata_r <= '0;
         host_rvalid_r <= 1'b0;
      end
      else
      begin
         host_rdata_r <= rdata_nxt;
         host_rvalid_r <= host_rd;
      end
   end

   // sample tick at the processor rate
   logic [$clog2(SAMPLE_DIV)-1:0] tick_cnt_r;
   logic tick_w;

   assign tick_w = tick_cnt_r == ($clog2(SAMPLE_DIV))'(SAMPLE_DIV - 1);

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         tick_cnt_r <= '0;
      else if (tick_w)
         tick_cnt_r <= '0;
      else
         tick_cnt_r <= tick_cnt_r + 1'b1;
   end

   // user tone: phase step of value/512 cycle per sample
   logic gen_user_w;

   assign gen_user_w = tone_type_r == GEN_TYPE_USER;

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         user_tone_on_r <= 1'b0;
         user_tone_phase_r <= '0;
         user_tone_amp_r <= '0;
      end
      else
      begin
         user_tone_on_r <= gen_user_w;
         if (!gen_user_w)
            user_tone_phase_r <= '0;
         else if (tick_w)
            user_tone_phase_r <= user_tone_phase_r +
               params_r[IDX_TONE_FREQ][PHASE_W-1:0];
         user_tone_amp_r <= gen_user_w ? params_r[IDX_GEN_LVL] : '0;
      end
   end

endmodule

// ---- tb/dspip_host.sv ----
`timescale 1ns/1ns
// host issuing conduit register commands
module dspip_host
   import dspip_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // conduit
   output logic host_wr,
   output logic host_rd,
   output logic [1:0] host_sel,
   output logic [7:0] host_wdata,
   input wire logic [7:0] host_rdata_r,
   input wire logic host_rvalid_r
);
   // idle bus at time zero
   initial
   begin
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_sel = 2'd3;
      host_wdata = 8'h00;
   end

   // one write strobe, bus inverted once released
   task automatic wr(input logic [1:0] s, input logic [7:0] d);
      @(posedge sys_clk);
      host_wr <= 1'b1;
      host_sel <= s;
      host_wdata <= d;
      @(posedge sys_clk);
      host_wr <= 1'b0;
      host_sel <= ~s;
      host_wdata <= ~d;
   endtask

   // one read strobe, answer taken once settled
   task automatic rd(input logic [1:0] s, output logic [7:0] q, output logic v);
      @(posedge sys_clk);
      host_rd <= 1'b1;
      host_sel <= s;
      @(posedge sys_clk);
      host_rd <= 1'b0;
      host_sel <= ~s;
      #1;
      q = host_rdata_r;
      v = host_rvalid_r;
   endtask

   // address first, then value high and low, back to address mode
   task automatic pset(input logic [15:0] a, input logic [15:0] d);
      wr(DSPIP_SEL_FUNC, FSEL_ADDR);
      wr(DSPIP_SEL_HIGH, a[15:8]);
      wr(DSPIP_SEL_LOW, a[7:0]);
      wr(DSPIP_SEL_FUNC, FSEL_VALUE);
      wr(DSPIP_SEL_HIGH, d[15:8]);
      wr(DSPIP_SEL_LOW, d[7:0]);
      wr(DSPIP_SEL_FUNC, FSEL_ADDR);
   endtask
endmodule

// ---- tb/dspip_props.sv ----
`timescale 1ns/1ns
// conduit and detector checks seen from the top ports
module dspip_props
   import dspip_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // conduit access
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [1:0] host_sel,
   input wire logic [7:0] host_wdata,
   input wire logic [7:0] host_rdata_r,
   input wire logic host_rvalid_r,
   // line state and energies
   input wire logic on_hook,
   input wire logic command_mode,
   input wire logic [13:0] carrier_energy,
   input wire logic [13:0] answer_energy,
   input wire logic [13:0] progress_energy,
   // results
   input wire logic [NPARAM-1:0][13:0] params_r,
   input wire logic param_refused_r,
   input wire logic square_en_r,
   input wire logic cascade_dis_r,
   input wire logic [4:0] report_en_r,
   input wire logic [3:0] dtmf_tx_digit_r,
   input wire logic [2:0] tone_type_r,
   input wire logic carrier_valid_r,
   input wire logic answer_valid_r,
   input wire logic progress_hit_r,
   input wire logic user_tone_on_r,
   input wire logic [13:0] user_tone_amp_r
);
   logic [7:0] fsel_r;
   logic val_lo_w;
   logic line_ok_w;
   logic tone_w;

   // shadow of the function select, decoded with the old value
   always_ff @(posedge sys_clk or negedge reset_n)
      if (!reset_n)
         fsel_r <= 8'h00;
      else if (host_wr && host_sel == 2'd0)
         fsel_r <= host_wdata;

   // value low write and line state decode
   assign val_lo_w = host_wr && host_sel == 2'd2 && fsel_r == FSEL_VALUE;
   assign line_ok_w = on_hook && command_mode;
   assign tone_w = host_sel == 2'd2 && fsel_r == FSEL_TONE;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   rd_answer_a: assert property (host_rd |=> host_rvalid_r)
      else $error("read not answered");
   rd_idle_a: assert property (!host_rd |=> !host_rvalid_r && host_rdata_r == 8'h00)
      else $error("answer without read");
   stat_rsvd_a: assert property (host_rd && tone_w |=> host_rdata_r[5] == 1'b0)
      else $error("status reserved bit set");
   val_refuse_a: assert property (val_lo_w && !line_ok_w |=> param_refused_r)
      else $error("off-hook value write taken");
   val_accept_a: assert property (val_lo_w && line_ok_w |=> !param_refused_r)
      else $error("on-hook value write refused");
   tone_ctl_a: assert property (host_wr && host_sel == 2'd1 && fsel_r == FSEL_TONE |=>
      {square_en_r, cascade_dis_r, report_en_r} == {$past(host_wdata[7:6]), $past(host_wdata[4:0])})
      else $error("tone control byte lost");
   tone_gen_a: assert property (host_wr && tone_w |=>
      {dtmf_tx_digit_r, tone_type_r} == $past(host_wdata[6:0]))
      else $error("tone generate byte lost");
   prog_cmp_a: assert property (1'b1 |=>
      progress_hit_r == $past(progress_energy >= params_r[IDX_PROG_LVL]))
      else $error("progress compare wrong");
   car_on_a: assert property (carrier_energy >= params_r[IDX_CAR_ON] &&
      carrier_energy >= params_r[IDX_CAR_OFF] |=> carrier_valid_r)
      else $error("carrier not valid");
   car_off_a: assert property (carrier_energy < params_r[IDX_CAR_ON] &&
      carrier_energy < params_r[IDX_CAR_OFF] |=> !carrier_valid_r)
      else $error("carrier still valid");
   ans_on_a: assert property (answer_energy >= params_r[IDX_ANS_ON] &&
      answer_energy >= params_r[IDX_ANS_OFF] |=> answer_valid_r)
      else $error("answer tone not valid");
   user_tone_a: assert property ((tone_type_r == GEN_TYPE_USER &&
      $stable(params_r[IDX_GEN_LVL])) [*2]
      |-> user_tone_on_r && user_tone_amp_r == params_r[IDX_GEN_LVL])
      else $error("user tone level wrong");

   // main scenarios reached
   cover property (val_lo_w && line_ok_w);
   cover property (host_rd && tone_w ##1 host_rdata_r[7]);
   cover property (user_tone_on_r);
endmodule

bind dspip_top dspip_props p_u (.sys_clk, .reset_n, .host_wr, .host_rd, .host_sel, .host_wdata,
   .host_rdata_r, .host_rvalid_r, .on_hook, .command_mode, .carrier_energy, .answer_energy,
   .progress_energy, .params_r, .param_refused_r, .square_en_r, .cascade_dis_r, .report_en_r,
   .dtmf_tx_digit_r, .tone_type_r, .carrier_valid_r, .answer_valid_r, .progress_hit_r,
   .user_tone_on_r, .user_tone_amp_r);

// ---- tb/dspip_top_tb.sv ----
`timescale 1ns/1ns
// self-checking bench for the conduit parameter port
module dspip_top_tb
   import dspip_pkg::*;
();
   localparam int DIV = 8;
   localparam logic [15:0] ADR [15] = '{16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006,
      16'h0007, 16'h0008, 16'h0009, 16'h000a, 16'h000b, 16'h000e, 16'h0024, 16'h0025,
      16'h0026, 16'h0027};
   localparam logic [13:0] DEF [15] = '{14'h1000, 14'h1304, 14'h0ccd, 14'h005b, 14'h1000,
      14'h137b, 14'h0218, 14'h137b, 14'h0218, 14'h0b50, 14'h1000, 14'h0a3c, 14'h0ce4,
      14'h0043, 14'h0025};
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic host_wr, host_rd, host_rvalid_r, on_hook, command_mode, dtmf_hit, v23_hit;
   logic [1:0] host_sel;
   logic [7:0] host_wdata, host_rdata_r;
   logic [3:0] dtmf_code, user_hit_r, dtmf_tx_digit_r;
   logic [13:0] carrier_energy, answer_energy, progress_energy, user_tone_amp_r;
   logic [3:0][13:0] user_energy;
   logic [NPARAM-1:0][13:0] params_r;
   logic param_bad_addr_r, param_refused_r, square_en_r, cascade_dis_r, carrier_valid_r;
   logic answer_valid_r, progress_hit_r, user_tone_on_r;
   logic [4:0] report_en_r;
   logic [2:0] tone_type_r;
   logic [PHASE_W-1:0] user_tone_phase_r;
   logic [13:0] shadow [15];
   logic [31:0] seed = 32'he8db;
   int n_mismatch = 0;
   int check_count = 0;
   int cyc = 0;
   int n_bad = 0;

   dspip_host host_u (.sys_clk, .host_wr, .host_rd, .host_sel, .host_wdata, .host_rdata_r,
      .host_rvalid_r);
   dspip_top #(.SAMPLE_DIV(DIV)) dut_u (.sys_clk, .reset_n, .host_wr, .host_rd, .host_sel,
      .host_wdata, .host_rdata_r, .host_rvalid_r, .on_hook, .command_mode, .dtmf_hit,
      .dtmf_code, .v23_hit, .carrier_energy, .answer_energy, .progress_energy, .user_energy,
      .params_r, .param_bad_addr_r, .param_refused_r, .square_en_r, .cascade_dis_r,
      .report_en_r, .dtmf_tx_digit_r, .tone_type_r, .carrier_valid_r, .answer_valid_r,
      .progress_hit_r, .user_hit_r, .user_tone_on_r, .user_tone_phase_r, .user_tone_amp_r);

   // clock
   always #2 sys_clk = ~sys_clk;

   // repeatable random source
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // expected tone status byte
   function automatic logic [7:0] stat_exp(input logic av, input logic [4:0] ty);
      return {av, ty != 5'h00, 1'b0, ty};
   endfunction

   // compare a parameter value
   task automatic chk_val(input logic [13:0] got, input logic [13:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask

   // compare a byte or flags
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
      end
   endtask

   // whole parameter map against the shadow
   task automatic chk_all();
      @(negedge sys_clk);
      for (int i = 0; i < 15; i++)
         chk_val(params_r[i], shadow[i]);
   endtask

   // conduit read with answer check
   task automatic rchk(input logic [1:0] s, input logic [7:0] e);
      logic [7:0] q;
      logic v;
      host_u.rd(s, q, v);
      chk_byte({7'h0, v}, 8'h01);
      chk_byte(q, e);
   endtask

   // counts and verdict
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // hang guard
   always @(posedge sys_clk)
   begin
      cyc++;
      n_bad += int'(param_bad_addr_r); // unmapped commit pulses seen
      if (cyc == 20000)
      begin
         n_mismatch++;
         end_sim();
      end
   end

   // main sequence
   initial
   begin
      logic [15:0] d;
      logic [8:0] p0;
      logic [3:0] code;
      {on_hook, command_mode, dtmf_hit, v23_hit} = 4'b1100;
      dtmf_code = 4'h0;
      {carrier_energy, answer_energy, progress_energy} = '0;
      user_energy = '0;
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      shadow = DEF;
      chk_all();
      for (int i = 0; i < 15; i++)
      begin
         d = (i == 0) ? 16'hffff : 16'(xs());
         host_u.pset(ADR[i], d);
         shadow[i] = d[13:0];
         chk_all();
      end
      host_u.pset(16'h0015, 16'h0135);
      chk_all();
      chk_val(14'(n_bad), 14'h0001);
      for (int k = 0; k < 2; k++)
      begin
         @(posedge sys_clk);
         on_hook <= k[0];
         command_mode <= !k[0];
         host_u.pset(ADR[3], {2'b00, ~shadow[3]});
         chk_all();
      end
      @(posedge sys_clk);
      on_hook <= 1'b1;
      command_mode <= 1'b1;
      host_u.wr(DSPIP_SEL_FUNC, FSEL_TONE);
      for (int i = 0; i < 5; i++)
      begin
         d = (i == 4) ? 16'h0036 : 16'(xs());
         host_u.wr(DSPIP_SEL_HIGH, d[15:8]);
         host_u.wr(DSPIP_SEL_LOW, d[7:0]);
         @(negedge sys_clk);
         chk_byte({square_en_r, cascade_dis_r, 1'b0, report_en_r}, d[15:8] & 8'hdf);
         chk_byte({1'b0, dtmf_tx_digit_r, tone_type_r}, d[7:0] & 8'h7f);
      end
      repeat (3) @(negedge sys_clk);
      chk_byte({7'h0, user_tone_on_r}, 8'h01);
      chk_val(user_tone_amp_r, shadow[9]);
      p0 = user_tone_phase_r;
      repeat (4 * DIV) @(negedge sys_clk);
      chk_val({5'h0, user_tone_phase_r - p0}, {5'h0, 9'(4 * shadow[3][8:0])});
      @(posedge sys_clk);
      code = 4'(xs());
      dtmf_hit <= 1'b1;
      v23_hit <= 1'b1;
      dtmf_code <= code;
      host_u.wr(DSPIP_SEL_HIGH, 8'h1f);
      repeat (2) @(posedge sys_clk);
      rchk(DSPIP_SEL_LOW, stat_exp(1'b1, {1'b1, code}));
      rchk(DSPIP_SEL_LOW, stat_exp(1'b0, {1'b1, code}));
      host_u.wr(DSPIP_SEL_HIGH, 8'h04);
      repeat (2) @(posedge sys_clk);
      rchk(DSPIP_SEL_LOW, stat_exp(1'b1, TT_V23));
      host_u.wr(DSPIP_SEL_HIGH, 8'h00);
      repeat (2) @(posedge sys_clk);
      rchk(DSPIP_SEL_LOW, stat_exp(1'b0, TT_NONE));
      rchk(DSPIP_SEL_HIGH, 8'h00);
      rchk(DSPIP_SEL_FUNC, FSEL_TONE);
      repeat (300)
      begin
         @(posedge sys_clk);
         carrier_energy <= 14'(xs());
         answer_energy <= 14'(xs() & 32'hff);
         progress_energy <= 14'(xs());
         user_energy <= 56'({xs(), xs()});
      end
      repeat (2) @(negedge sys_clk);
      chk_byte({7'h0, progress_hit_r}, {7'h0, progress_energy >= shadow[4]});
      for (int i = 0; i < 4; i++)
         chk_byte({7'h0, user_hit_r[i]}, {7'h0, user_energy[i] >= shadow[10]});
      for (int j = 1; j >= 0; j--)
      begin
         @(posedge sys_clk);
         carrier_energy <= {14{j[0]}};
         answer_energy <= {14{j[0]}};
         repeat (3) @(negedge sys_clk);
         chk_byte({6'h0, carrier_valid_r, answer_valid_r}, {6'h0, {2{j[0]}}});
      end
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      shadow = DEF;
      chk_all();
      rchk(DSPIP_SEL_FUNC, FSEL_RESET);
      end_sim();
   end
endmodule
